// File: logic/msr_meter_status_regs.sv
// metering status, result, peak and interrupt enable register bank
`timescale 1ns/10ps

module msr_meter_status_regs
    import msr_pkg::*;
#(
    parameter logic [15:0] INST_DIV_CYCLES = 16'(INST_DIV_DEFAULT)  // clocks per refresh
) (
    input  wire logic                clock,             // 100 MHz system clock
    input  wire logic                rst,               // synchronous reset, active high
    // register access port
    input  wire logic [ADDR_W-1:0]   reg_addr,          // register address
    input  wire logic                reg_wr,            // write strobe, one cycle
    input  wire logic                reg_rd,            // read strobe, one cycle
    input  wire logic [31:0]         reg_wdata,         // write data
    output logic      [31:0]         reg_rdata,         // read data
    output logic                     reg_rvalid,        // read data valid, one cycle
    input  wire logic                write_unlock,      // enable register write permitted
    // datapath inputs
    input  wire logic                chan_b_request,    // datapath wants channel B
    input  wire logic                second_current_adc_on, // second current adc enabled
    input  wire logic [31:0]         power_a,           // channel A active power, signed
    input  wire logic [31:0]         power_b,           // channel B active power, signed
    input  wire logic                energy_pulse_a,    // channel A energy pulse
    input  wire logic                energy_pulse_b,    // channel B energy pulse
    input  wire msr_cal_type         cal_values,        // calibration registers 00H-1FH
    input  wire logic                peak_valid,        // new peak candidate samples
    input  wire logic [23:0]         peak_ia_in,        // current A magnitude sample
    input  wire logic [23:0]         peak_ib_in,        // current B magnitude sample
    input  wire logic [23:0]         peak_u_in,         // voltage magnitude sample
    input  wire msr_sample_type      sample_in,         // live instantaneous values
    input  wire logic [15:0]         irq_events,        // event pulses, enable bit map
    // status outputs
    output logic      [23:0]         metering_status,   // live status word
    output logic                     irq_n              // interrupt, active low
);

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------

    // inverted 16 bit running sum of the calibration block
    function automatic logic [15:0] cal_checksum(input msr_cal_type vals);
        logic [15:0] sum;
        logic [15:0] word;
        sum = 16'h0000;
        for (int i = 0; i < CAL_REG_COUNT; i++) begin
            word = vals[i];
            // single byte registers carry a zero upper byte
            if (CAL_BYTE_MASK[i]) begin
                word[15:8] = 8'h00;
            end
            sum = sum + word;
        end
        return ~sum;
    endfunction : cal_checksum

    // magnitude of a signed power word
    function automatic logic [31:0] power_mag(input logic [31:0] p);
        return p[31] ? (~p + 32'h0000_0001) : p;
    endfunction : power_mag

    // peak tracker: read clears, a new larger sample still lands
    function automatic logic [23:0] peak_next(input logic [23:0] cur,
                                              input logic        clr,
                                              input logic        vld,
                                              input logic [23:0] smp);
        logic [23:0] base;
        base = clr ? 24'h000000 : cur;
        if (vld && (smp > base)) begin
            base = smp;
        end
        return base;
    endfunction : peak_next

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    msr_state_type  state_q;                 // all registered state
    msr_state_type  state_d;                 // next state
    logic           wr_cal;                  // write into the calibration block
    logic           rd_status;               // read of the status word
    logic           rd_flags;                // read of the flag register
    logic           inst_tick;               // refresh enable at instant rate
    logic           restart;                 // checksum restart request
    logic [15:0]    event_set;               // enabled events this cycle
    logic [23:0]    status_word;             // assembled status word

    // ------------------------------------------------------------------
    // decode and status assembly
    // ------------------------------------------------------------------

    // access decode
    assign wr_cal    = reg_wr && (reg_addr <= CAL_LAST_ADDR);
    assign rd_status = reg_rd && (reg_addr == ADDR_STATUS);
    assign rd_flags  = reg_rd && (reg_addr == ADDR_IRQ_FLAGS);
    assign restart   = wr_cal || rd_status;

    // refresh enable when the divider wraps
    assign inst_tick = (state_q.div_cnt == 16'h0000);

    // status word, bits 23:22 unused and zero
    always_comb begin
        status_word               = 24'h000000;
        status_word[ST_CHAN_SEL]  = state_q.chan_sel;
        status_word[ST_NO_LOAD_B] = state_q.no_load_b;
        status_word[ST_NO_LOAD_A] = state_q.no_load_a;
        status_word[ST_REV_B]     = state_q.rev_b;
        status_word[ST_REV_A]     = state_q.rev_a;
        status_word[ST_CHK_BUSY]  = state_q.chk_busy;
        status_word[15:0]         = state_q.checksum;
    end

    // events that may raise a flag, gated by the enables
    always_comb begin
        event_set             = irq_events;
        event_set[IE_INSTANT] = irq_events[IE_INSTANT] | inst_tick;
        event_set[IE_PULSE_A] = irq_events[IE_PULSE_A] | energy_pulse_a;
        event_set[IE_PULSE_B] = irq_events[IE_PULSE_B] | energy_pulse_b;
        event_set             = event_set & state_q.irq_en & IRQ_VALID_MASK;
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        state_d        = state_q;
        state_d.rvalid = 1'b0;

        // channel selection follows the datapath unless adc2 forces A
        if (second_current_adc_on) begin
            state_d.chan_sel = 1'b0;
        end else begin
            state_d.chan_sel = chan_b_request;
        end

        // no-load flags track power against the start threshold
        state_d.no_load_b = (power_mag(power_b) < START_POWER);
        state_d.no_load_a = (power_mag(power_a) < START_POWER);

        // reverse flags only move on an energy pulse
        if (energy_pulse_b) begin
            state_d.rev_b = power_b[31];
        end
        if (energy_pulse_a) begin
            state_d.rev_a = power_a[31];
        end

        // checksum engine: busy for two cycles, then value latched
        if (restart) begin
            state_d.chk_busy = 1'b1;
            state_d.chk_cnt  = CHK_CYCLES;
        end else if (state_q.chk_cnt != 2'h0) begin
            state_d.chk_cnt = state_q.chk_cnt - 2'h1;
            // final cycle: take the value and drop busy
            if (state_q.chk_cnt == 2'h1) begin
                state_d.checksum = cal_checksum(cal_values);
                state_d.chk_busy = 1'b0;
            end
        end

        // peak registers, cleared by the read that returns them
        state_d.peak_ia = peak_next(state_q.peak_ia,
                                    reg_rd && (reg_addr == ADDR_PEAK_IA),
                                    peak_valid, peak_ia_in);
        state_d.peak_ib = peak_next(state_q.peak_ib,
                                    reg_rd && (reg_addr == ADDR_PEAK_IB),
                                    peak_valid, peak_ib_in);
        state_d.peak_u  = peak_next(state_q.peak_u,
                                    reg_rd && (reg_addr == ADDR_PEAK_U),
                                    peak_valid, peak_u_in);

        // instant refresh divider
        if (inst_tick) begin
            state_d.div_cnt = INST_DIV_CYCLES - 16'h0001;
            state_d.inst    = sample_in;
        end else begin
            state_d.div_cnt = state_q.div_cnt - 16'h0001;
        end

        // protected enable register, reserved bit held at zero
        if (reg_wr && (reg_addr == ADDR_IRQ_EN) && write_unlock) begin
            state_d.irq_en = reg_wdata[15:0] & IRQ_VALID_MASK;
        end

        // flags: read clears, but a same-cycle event wins
        if (rd_flags) begin
            state_d.irq_flags = event_set;
        end else begin
            state_d.irq_flags = state_q.irq_flags | event_set;
        end

        // read data multiplexer
        if (reg_rd) begin
            state_d.rvalid = 1'b1;
            unique case (reg_addr)
                ADDR_STATUS:    state_d.rdata = {8'h00, status_word};
                ADDR_PEAK_IA:   state_d.rdata = {8'h00, state_q.peak_ia};
                ADDR_PEAK_IB:   state_d.rdata = {8'h00, state_q.peak_ib};
                ADDR_PEAK_U:    state_d.rdata = {8'h00, state_q.peak_u};
                ADDR_RMS_IA:    state_d.rdata = {8'h00, state_q.inst.rms_ia};
                ADDR_RMS_IB:    state_d.rdata = {8'h00, state_q.inst.rms_ib};
                ADDR_RMS_U:     state_d.rdata = {8'h00, state_q.inst.rms_u};
                ADDR_WAVE_IA:   state_d.rdata = {8'h00, state_q.inst.wave_ia};
                ADDR_WAVE_IB:   state_d.rdata = {8'h00, state_q.inst.wave_ib};
                ADDR_WAVE_U:    state_d.rdata = {8'h00, state_q.inst.wave_u};
                ADDR_P_ACT:     state_d.rdata = state_q.inst.p_act;
                ADDR_P_APP:     state_d.rdata = state_q.inst.p_app;
                ADDR_IRQ_EN:    state_d.rdata = {16'h0000, state_q.irq_en};
                ADDR_IRQ_FLAGS: state_d.rdata = {16'h0000, state_q.irq_flags};
                // anything else reads as zero
                default:        state_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q           <= '0;
            state_q.checksum  <= CHECKSUM_RESET;
            // reset starts a fresh checksum run
            state_q.chk_busy  <= 1'b1;
            state_q.chk_cnt   <= CHK_CYCLES;
            state_q.irq_en    <= IRQ_EN_RESET;
            state_q.div_cnt   <= INST_DIV_CYCLES - 16'h0001;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign reg_rdata       = state_q.rdata;
    assign reg_rvalid      = state_q.rvalid;
    assign metering_status = status_word;

    // pin low while any enabled flag stands
    assign irq_n = ~|(state_q.irq_flags & state_q.irq_en);

endmodule : msr_meter_status_regs

// File: logic/msr_pkg.sv
// package of constants and types for the metering status and result register bank
package msr_pkg;

    // ------------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------------
    localparam int          ADDR_W           = 7;
    localparam logic [6:0]  CAL_LAST_ADDR    = 7'h1F;
    localparam logic [6:0]  ADDR_STATUS      = 7'h2F;
    localparam logic [6:0]  ADDR_PEAK_IA     = 7'h30;
    localparam logic [6:0]  ADDR_PEAK_IB     = 7'h31;
    localparam logic [6:0]  ADDR_PEAK_U      = 7'h32;
    localparam logic [6:0]  ADDR_RMS_IA      = 7'h33;
    localparam logic [6:0]  ADDR_RMS_IB      = 7'h34;
    localparam logic [6:0]  ADDR_RMS_U       = 7'h35;
    localparam logic [6:0]  ADDR_WAVE_IA     = 7'h36;
    localparam logic [6:0]  ADDR_WAVE_IB     = 7'h37;
    localparam logic [6:0]  ADDR_WAVE_U      = 7'h38;
    localparam logic [6:0]  ADDR_P_ACT       = 7'h3C;
    localparam logic [6:0]  ADDR_P_APP       = 7'h3D;
    localparam logic [6:0]  ADDR_IRQ_EN      = 7'h40;
    localparam logic [6:0]  ADDR_IRQ_FLAGS   = 7'h41;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int          ST_CHAN_SEL      = 21;
    localparam int          ST_NO_LOAD_B     = 20;
    localparam int          ST_NO_LOAD_A     = 19;
    localparam int          ST_REV_B         = 18;
    localparam int          ST_REV_A         = 17;
    localparam int          ST_CHK_BUSY      = 16;
    localparam int          IE_INSTANT       = 6;
    localparam int          IE_PULSE_B       = 2;
    localparam int          IE_PULSE_A       = 1;
    localparam logic [15:0] CHECKSUM_RESET   = 16'hEF3B;
    localparam logic [15:0] IRQ_EN_RESET     = 16'h0000;
    localparam logic [15:0] IRQ_VALID_MASK   = 16'hFFDF;
    localparam logic [31:0] START_POWER      = 32'h0000_0060;

    // ------------------------------------------------------------------
    // checksum source and timing
    // ------------------------------------------------------------------
    localparam int          CAL_REG_COUNT    = 32;
    localparam logic [31:0] CAL_BYTE_MASK    = 32'h0000_0000;
    localparam logic [1:0]  CHK_CYCLES       = 2'h2;
    localparam int          CLOCK_HZ         = 100_000_000;
    localparam int          INST_RATE_HZ     = 6991;
    localparam int          INST_DIV_DEFAULT = CLOCK_HZ / INST_RATE_HZ;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef logic [CAL_REG_COUNT-1:0][15:0] msr_cal_type;

    // live values from the measurement datapath
    typedef struct packed {
        logic [23:0] rms_ia;
        logic [23:0] rms_ib;
        logic [23:0] rms_u;
        logic [23:0] wave_ia;
        logic [23:0] wave_ib;
        logic [23:0] wave_u;
        logic [31:0] p_act;
        logic [31:0] p_app;
    } msr_sample_type;

    // complete state of the register bank
    typedef struct packed {
        logic             chan_sel;
        logic             no_load_b;
        logic             no_load_a;
        logic             rev_b;
        logic             rev_a;
        logic             chk_busy;
        logic [1:0]       chk_cnt;
        logic [15:0]      checksum;
        logic [23:0]      peak_ia;
        logic [23:0]      peak_ib;
        logic [23:0]      peak_u;
        msr_sample_type   inst;
        logic [15:0]      irq_en;
        logic [15:0]      irq_flags;
        logic [15:0]      div_cnt;
        logic [31:0]      rdata;
        logic             rvalid;
    } msr_state_type;

endpackage : msr_pkg

// File: test/msr_host_model.sv
// host model driving the register access port
`timescale 1ns/10ps

module msr_host_model
    import msr_pkg::*;
(
    input  wire logic              clock,
    output logic      [ADDR_W-1:0] reg_addr,
    output logic                   reg_wr,
    output logic                   reg_rd,
    output logic      [31:0]       reg_wdata,
    input  wire logic [31:0]       reg_rdata,
    input  wire logic              reg_rvalid
);
    // idle bus at time zero
    initial begin
        reg_addr = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = '0;
    end
    // one write strobe, then released lines show inverted values
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~v;
    endtask : wr
    // one read strobe, data taken while valid stands
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        v = (reg_rvalid === 1'b1) ? reg_rdata : 'x;
    endtask : rd
endmodule : msr_host_model

// File: test/msr_meter_status_chk.sv
// assertion checker for the metering status register bank
`timescale 1ns/10ps

module msr_meter_status_chk
    import msr_pkg::*;
(
    input wire logic              clock,
    input wire logic              rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_wdata,
    input wire logic [31:0]       reg_rdata,
    input wire logic              reg_rvalid,
    input wire logic              write_unlock,
    input wire logic              chan_b_request,
    input wire logic              second_current_adc_on,
    input wire logic [31:0]       power_a,
    input wire logic [31:0]       power_b,
    input wire logic              energy_pulse_a,
    input wire logic              energy_pulse_b,
    input wire logic [15:0]       irq_events,
    input wire logic [23:0]       metering_status,
    input wire logic              irq_n
);
    // ------------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------------
    logic [31:0] mag_a;   // channel A power magnitude
    logic [31:0] mag_b;   // channel B power magnitude
    logic        restart; // checksum restart request
    logic [15:0] en_q;    // shadow of the enable register
    assign mag_a = power_a[31] ? -power_a : power_a;
    assign mag_b = power_b[31] ? -power_b : power_b;
    assign restart = (reg_rd && reg_addr == ADDR_STATUS) || (reg_wr && reg_addr <= CAL_LAST_ADDR);
    // enable shadow follows only unlocked writes
    always_ff @(posedge clock) begin
        if (rst) begin
            en_q <= IRQ_EN_RESET;
        end else if (reg_wr && write_unlock && reg_addr == ADDR_IRQ_EN) begin
            en_q <= reg_wdata[15:0] & IRQ_VALID_MASK;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    property p_chan_b;
        chan_b_request && !second_current_adc_on |=> metering_status[ST_CHAN_SEL]; endproperty
    a_chan_b: assert property (p_chan_b) else $error("channel select not set");
    property p_chan_off; second_current_adc_on |=> !metering_status[ST_CHAN_SEL]; endproperty
    a_chan_off: assert property (p_chan_off) else $error("channel select not forced low");
    property p_noload_b;
        !rst |=> metering_status[ST_NO_LOAD_B] == ($past(mag_b) < START_POWER); endproperty
    a_noload_b: assert property (p_noload_b) else $error("channel B no-load wrong");
    property p_noload_a;
        !rst |=> metering_status[ST_NO_LOAD_A] == ($past(mag_a) < START_POWER); endproperty
    a_noload_a: assert property (p_noload_a) else $error("channel A no-load wrong");
    property p_rev_b;
        energy_pulse_b |=> metering_status[ST_REV_B] == $past(power_b[31]); endproperty
    a_rev_b: assert property (p_rev_b) else $error("channel B reverse flag wrong");
    property p_rev_a; !energy_pulse_a |=> $stable(metering_status[ST_REV_A]); endproperty
    a_rev_a: assert property (p_rev_a) else $error("channel A reverse flag moved");
    property p_busy; restart |=> metering_status[ST_CHK_BUSY] [*2]; endproperty
    a_busy: assert property (p_busy) else $error("checksum busy not raised");
    property p_done;
        restart ##1 !restart ##1 !restart |=> !metering_status[ST_CHK_BUSY]; endproperty
    a_done: assert property (p_done) else $error("checksum busy too long");
    property p_rd_st; reg_rd && reg_addr == ADDR_STATUS |=>
        reg_rvalid && reg_rdata == {8'h00, $past(metering_status)}; endproperty
    a_rd_st: assert property (p_rd_st) else $error("status read data wrong");
    property p_resv; 1 |-> metering_status[23:22] == 2'h0; endproperty
    a_resv: assert property (p_resv) else $error("reserved status bits set");
    property p_irq; |(irq_events & en_q) |=> !irq_n; endproperty
    a_irq: assert property (p_irq) else $error("interrupt pin not low");
    property p_irq_off; en_q == 16'h0000 |-> irq_n; endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt low while disabled");
endmodule : msr_meter_status_chk

bind msr_meter_status_regs msr_meter_status_chk i_chk (.clock, .rst, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .reg_rvalid, .write_unlock, .chan_b_request, .second_current_adc_on,
    .power_a, .power_b, .energy_pulse_a, .energy_pulse_b, .irq_events, .metering_status, .irq_n);

// File: test/tb_top.sv
// self-checking testbench of the metering status register bank
`timescale 1ns/10ps

module tb_top
    import msr_pkg::*;
;
    logic clock, rst, wr, rd, rvalid, write_unlock, chan_b_request, second_current_adc_on;
    logic energy_pulse_a, energy_pulse_b, peak_valid, irq_n;
    logic [ADDR_W-1:0] addr;
    logic [31:0]  wdata, rdata, power_a, power_b, d, r, pa, pb, seed;
    logic [23:0]  peak_ia_in, peak_ib_in, peak_u_in, metering_status;
    logic [15:0]  irq_events;
    msr_cal_type  cal_values;
    msr_sample_type sample_in, smp;
    logic         rev_a_m, rev_b_m;     // model reverse flags
    int           err_total, n_tests, k, pk_m[3];
    logic [6:0]   ia[8];
    logic [31:0]  ie[8];
    msr_meter_status_regs #(.INST_DIV_CYCLES(16'h0010)) i_msr_meter_status_regs (.clock(clock),
        .rst(rst), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata),
        .reg_rvalid(rvalid), .write_unlock(write_unlock), .chan_b_request(chan_b_request),
        .second_current_adc_on(second_current_adc_on), .power_a(power_a), .power_b(power_b),
        .energy_pulse_a(energy_pulse_a), .energy_pulse_b(energy_pulse_b), .cal_values(cal_values),
        .peak_valid(peak_valid), .peak_ia_in(peak_ia_in), .peak_ib_in(peak_ib_in),
        .peak_u_in(peak_u_in), .sample_in(sample_in), .irq_events(irq_events),
        .metering_status(metering_status), .irq_n(irq_n));
    msr_host_model i_msr_host_model (.clock(clock), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
        .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid));
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    // model of the status word from the bench's own inputs
    function automatic logic [31:0] exp_status();
        int s;
        logic [31:0] ma, mb;
        s = 0;
        for (int i = 0; i < CAL_REG_COUNT; i++) s += int'(cal_values[i]);
        ma = power_a[31] ? -power_a : power_a;
        mb = power_b[31] ? -power_b : power_b;
        return {10'h000, chan_b_request & ~second_current_adc_on, mb < 32'h60, ma < 32'h60,
                rev_b_m, rev_a_m, 1'b0, ~s[15:0]};
    endfunction : exp_status
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic conclude();
        if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge clock);
        err_total++;
        conclude();
    end
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        {rst, err_total, n_tests, seed} = {1'b1, 32'd0, 32'd0, 32'd67};
        {write_unlock, chan_b_request, second_current_adc_on, energy_pulse_a} = 4'h0;
        {energy_pulse_b, peak_valid, rev_a_m, rev_b_m, irq_events} = '0;
        {power_a, power_b, peak_ia_in, peak_ib_in, peak_u_in, sample_in} = '0;
        pk_m = '{0, 0, 0};
        for (k = 0; k < CAL_REG_COUNT; k++) cal_values[k] = 16'(xs() >> 16);
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        i_msr_host_model.rd(ADDR_RMS_IA, d);
        chk("rms_ia_reset", 32'h0, d);
        repeat (3) @(posedge clock);
        i_msr_host_model.rd(ADDR_STATUS, d);
        chk("status_reset", exp_status(), d);
        // status bits and checksum under random inputs
        for (k = 0; k < 10; k++) begin
            r = xs();
            pa = r[8] ? 32'(signed'(r[15:9]) - 7'sd40) : xs();
            pb = r[16] ? 32'(signed'(r[23:17]) - 7'sd40) : xs();
            @(posedge clock);
            {power_a, power_b, chan_b_request, second_current_adc_on} <= {pa, pb, r[1:0]};
            {energy_pulse_a, energy_pulse_b} <= r[3:2];
            if (r[4]) cal_values[r[30:26]] <= r[31:16];
            if (r[3]) rev_a_m = pa[31];
            if (r[2]) rev_b_m = pb[31];
            @(posedge clock);
            {energy_pulse_a, energy_pulse_b} <= 2'h0;
            if (r[4]) i_msr_host_model.wr(7'(r[30:26]), xs());
            repeat (3) @(posedge clock);
            i_msr_host_model.rd(ADDR_STATUS, d);
            chk("status", exp_status(), d);
        end
        // peak capture and clear on read
        for (k = 0; k < 6; k++) begin
            r = xs();
            @(posedge clock);
            {peak_valid, peak_ia_in, peak_ib_in, peak_u_in} <= {1'b1, r[23:0], r[31:8], r[27:4]};
            pk_m = '{int'(r[23:0]) > pk_m[0] ? int'(r[23:0]) : pk_m[0],
                     int'(r[31:8]) > pk_m[1] ? int'(r[31:8]) : pk_m[1],
                     int'(r[27:4]) > pk_m[2] ? int'(r[27:4]) : pk_m[2]};
        end
        @(posedge clock);
        peak_valid <= 1'b0;
        for (k = 0; k < 3; k++) begin
            i_msr_host_model.rd(ADDR_PEAK_IA + 7'(k), d);
            chk("peak", 32'(pk_m[k]), d);
            i_msr_host_model.rd(ADDR_PEAK_IA + 7'(k), d);
            chk("peak_cleared", 32'h0, d);
        end
        // instantaneous and waveform registers after a refresh period
        smp = 208'({xs(), xs(), xs(), xs(), xs(), xs(), xs()});
        @(posedge clock);
        sample_in <= smp;
        ia = '{ADDR_RMS_IA, ADDR_RMS_IB, ADDR_RMS_U, ADDR_WAVE_IA, ADDR_WAVE_IB, ADDR_WAVE_U,
               ADDR_P_ACT, ADDR_P_APP};
        ie = '{32'(smp.rms_ia), 32'(smp.rms_ib), 32'(smp.rms_u), 32'(smp.wave_ia),
               32'(smp.wave_ib), 32'(smp.wave_u), smp.p_act, smp.p_app};
        repeat (20) @(posedge clock);
        for (k = 0; k < 8; k++) begin
            i_msr_host_model.rd(ia[k], d);
            chk("instant", ie[k], d);
        end
        // enable register protection, bit map and interrupt pin
        i_msr_host_model.wr(ADDR_IRQ_EN, 32'hFFFF);
        i_msr_host_model.rd(ADDR_IRQ_EN, d);
        chk("irq_en_locked", 32'h0, d);
        @(posedge clock);
        write_unlock <= 1'b1;
        i_msr_host_model.wr(ADDR_IRQ_EN, 32'hFFFF);
        i_msr_host_model.rd(ADDR_IRQ_EN, d);
        chk("irq_en", 32'h0000FFDF, d);
        i_msr_host_model.wr(ADDR_IRQ_EN, 32'h8001);
        i_msr_host_model.rd(ADDR_IRQ_FLAGS, d);
        chk("irq_n_cleared", 32'h1, 32'(irq_n));
        for (k = 0; k < 2; k++) begin
            @(posedge clock);
            irq_events <= k ? 16'h4000 : 16'h8000;
            @(posedge clock);
            irq_events <= 16'h0000;
            #1;
            chk("irq_n_event", 32'(k), 32'(irq_n));
            i_msr_host_model.rd(ADDR_IRQ_FLAGS, d);
            chk("irq_flags", k ? 32'h0 : 32'h8000, d);
            chk("irq_n_read", 32'h1, 32'(irq_n));
        end
        i_msr_host_model.rd(7'h50, d);
        chk("unmapped", 32'h0, d);
        conclude();
    end
endmodule : tb_top
